// ==== core/cvbo_field_reg.sv ====
// Software writable register field with a fixed reset value.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/10ps
module cvbo_field_reg #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] value
);

  always_ff @(posedge clk) begin
    if (rst) begin
      value <= RESET;
    end else if (wrEn) begin
      value <= wrData;
    end
  end

endmodule

// ==== core/cvbo_regs.sv ====
// Vector base and core options registers of the system control unit.
// Assumes the core issues one-cycle read and write strobes with a register
// number and select, and drives the boot vector select bit of its status
// register on the same clock. The core index arrives on pins.
`timescale 1ns/10ps
module cvbo_regs
  import cvbo_pkg::*;
#(
  parameter logic [31:0] OPTS_STATUS = cvbo_pkg::OPTS_RESET,
  parameter logic [31:0] BOOT_VECTOR_BASE = 32'h8000_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpRead,
  input wire logic cpWrite,
  input wire logic [4:0] cpRegNum,
  input wire logic [2:0] cpSel,
  input wire logic [31:0] cpWrData,
  input wire logic bootVectorSelect,
  input wire logic [cvbo_pkg::CORE_INDEX_W-1:0] coreIndexPins,
  output logic [31:0] cpRdData,
  output logic cpRdValid,
  output logic [31:0] vectorBase,
  output logic [cvbo_pkg::POLICY_W-1:0] cachedSegmentPolicy,
  output logic segmentCacheable,
  output logic segmentPolicyReserved,
  output logic nextRegPresent,
  output logic endianFlag,
  output logic [1:0] archType,
  output logic [2:0] isaRevision,
  output logic [2:0] mmuKind,
  output logic icacheLogicalTagged
);
  import cvbo_pkg::*;

  // ************************************************************
  // Address decode
  // ************************************************************
  logic hitVbase;
  logic hitOpts;
  logic wrVbase;
  logic wrOpts;

  assign hitVbase = (cpRegNum == VBASE_REG_NUM) && (cpSel == VBASE_REG_SEL);
  assign hitOpts = (cpRegNum == OPTS_REG_NUM) && (cpSel == OPTS_REG_SEL);
  assign wrVbase = cpWrite && hitVbase;
  assign wrOpts = cpWrite && hitOpts;

  // ************************************************************
  // Core index strap
  // ************************************************************
  logic [CORE_INDEX_W-1:0] coreIndexSync;
  logic [CORE_INDEX_W-1:0] coreIndex;

  cvbo_sync2 #(
    .WIDTH(CORE_INDEX_W)
  ) u_index_sync (
    .clk(clk),
    .pinIn(coreIndexPins),
    .syncOut(coreIndexSync)
  );

  // Index follows the pins while reset is held, then freezes
  always_ff @(posedge clk) begin
    if (rst) begin
      coreIndex <= coreIndexSync;
    end
  end

  // ************************************************************
  // Vector base register
  // ************************************************************
  logic [VBASE_BASE_W-1:0] vbaseField;
  logic [31:0] vbaseWord;
  logic [31:0] programmedBase;

  // Only the base field takes write data
  cvbo_field_reg #(
    .WIDTH(VBASE_BASE_W),
    .RESET(VBASE_BASE_RESET)
  ) u_vbase_field (
    .clk(clk),
    .rst(rst),
    .wrEn(wrVbase),
    .wrData(cpWrData[VBASE_BASE_MSB:VBASE_BASE_LSB]),
    .value(vbaseField)
  );

  // Fixed top bits, reserved zeros and core index ignore writes
  assign vbaseWord = {VBASE_TOP_VALUE, vbaseField, VBASE_RSV_VALUE, coreIndex};
  assign programmedBase = {VBASE_TOP_VALUE, vbaseField, VBASE_ALIGN_ZERO};

  // Exception vector base seen by the core
  always_ff @(posedge clk) begin
    if (rst) begin
      vectorBase <= BOOT_VECTOR_BASE;
    end else if (bootVectorSelect) begin
      vectorBase <= BOOT_VECTOR_BASE;
    end else begin
      vectorBase <= programmedBase;
    end
  end

  // ************************************************************
  // Core options register
  // ************************************************************
  logic [POLICY_W-1:0] policyField;
  logic [31:0] optsWord;
  logic [OPTS_STATUS_W-1:0] optsStatus;

  cvbo_field_reg #(
    .WIDTH(POLICY_W),
    .RESET(POLICY_RESET)
  ) u_policy_field (
    .clk(clk),
    .rst(rst),
    .wrEn(wrOpts),
    .wrData(cpWrData[POLICY_W-1:0]),
    .value(policyField)
  );

  // Status bits load at reset and never take write data
  always_ff @(posedge clk) begin
    if (rst) begin
      optsStatus <= OPTS_STATUS[31:OPTS_STATUS_LSB];
    end
  end

  assign optsWord = {optsStatus, policyField};

  // ************************************************************
  // Decoded configuration outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      nextRegPresent <= OPTS_STATUS[OPTS_NEXT_BIT];
      endianFlag <= OPTS_STATUS[OPTS_ENDIAN_BIT];
      archType <= OPTS_STATUS[OPTS_ARCH_MSB:OPTS_ARCH_LSB];
      isaRevision <= OPTS_STATUS[OPTS_ISA_MSB:OPTS_ISA_LSB];
      mmuKind <= OPTS_STATUS[OPTS_MMU_MSB:OPTS_MMU_LSB];
      icacheLogicalTagged <= OPTS_STATUS[OPTS_ICACHE_BIT];
    end else begin
      nextRegPresent <= optsWord[OPTS_NEXT_BIT];
      endianFlag <= optsWord[OPTS_ENDIAN_BIT];
      archType <= optsWord[OPTS_ARCH_MSB:OPTS_ARCH_LSB];
      isaRevision <= optsWord[OPTS_ISA_MSB:OPTS_ISA_LSB];
      mmuKind <= optsWord[OPTS_MMU_MSB:OPTS_MMU_LSB];
      icacheLogicalTagged <= optsWord[OPTS_ICACHE_BIT];
    end
  end

  // Policy steers cacheability of the unmapped cached segment
  assign cachedSegmentPolicy = policyField;

  always_ff @(posedge clk) begin
    if (rst) begin
      segmentCacheable <= 1'b0;
      segmentPolicyReserved <= 1'b0;
    end else begin
      segmentCacheable <= (policyField == POLICY_CACHEABLE);
      segmentPolicyReserved <= (policyField != POLICY_CACHEABLE) &&
        (policyField != POLICY_UNCACHED);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [31:0] next_cpRdData;

  // Reads return the value before a write in the same cycle
  always_comb begin
    if (hitVbase) begin
      next_cpRdData = vbaseWord;
    end else if (hitOpts) begin
      next_cpRdData = optsWord;
    end else begin
      next_cpRdData = UNMAPPED_READ;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpRdData <= UNMAPPED_READ;
      cpRdValid <= 1'b0;
    end else begin
      cpRdValid <= cpRead;
      if (cpRead) begin
        cpRdData <= next_cpRdData;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic readWasVbase;
  logic readWasOpts;

  always_ff @(posedge clk) begin
    if (rst) begin
      readWasVbase <= 1'b0;
      readWasOpts <= 1'b0;
    end else begin
      readWasVbase <= cpRead && hitVbase;
      readWasOpts <= cpRead && hitOpts;
    end
  end

  chk_vbase_top_bits: assert property (
    @(posedge clk) disable iff (rst)
    readWasVbase |-> cpRdData[VBASE_TOP_MSB:VBASE_TOP_LSB] == VBASE_TOP_VALUE)
  else $error("vector base top bits not one-zero");

  chk_vbase_reserved_zero: assert property (
    @(posedge clk) disable iff (rst)
    readWasVbase |-> cpRdData[VBASE_RSV_MSB:VBASE_RSV_LSB] == VBASE_RSV_VALUE)
  else $error("vector base reserved bits not zero");

  chk_core_index_fixed: assert property (
    @(posedge clk) disable iff (rst)
    (cpRead && hitVbase) |=> cpRdData[CORE_INDEX_W-1:0] == $past(coreIndex) &&
      $stable(coreIndex))
  else $error("core index changed or misreported");

  chk_vbase_write_lands: assert property (
    @(posedge clk) disable iff (rst)
    wrVbase ##1 (cpRead && hitVbase && !cpWrite) |=>
      cpRdData[VBASE_BASE_MSB:VBASE_BASE_LSB] ==
      $past(cpWrData[VBASE_BASE_MSB:VBASE_BASE_LSB], 2))
  else $error("vector base write not read back");

  chk_vector_select: assert property (
    @(posedge clk) disable iff (rst)
    !bootVectorSelect |=>
      vectorBase == {VBASE_TOP_VALUE, $past(vbaseField), VBASE_ALIGN_ZERO})
  else $error("programmed vector base not used");

  chk_boot_vector_used: assert property (
    @(posedge clk) disable iff (rst)
    bootVectorSelect |=> vectorBase == BOOT_VECTOR_BASE)
  else $error("boot vector base not used");

  chk_opts_status_fixed: assert property (
    @(posedge clk) disable iff (rst)
    readWasOpts |-> cpRdData[31:OPTS_STATUS_LSB] == OPTS_STATUS[31:OPTS_STATUS_LSB])
  else $error("options status bits changed");

  chk_decoded_fixed: assert property (
    @(posedge clk) disable iff (rst)
    {nextRegPresent, endianFlag, archType, isaRevision, mmuKind, icacheLogicalTagged} ==
      {OPTS_STATUS[OPTS_NEXT_BIT], OPTS_STATUS[OPTS_ENDIAN_BIT],
      OPTS_STATUS[OPTS_ARCH_MSB:OPTS_ARCH_LSB], OPTS_STATUS[OPTS_ISA_MSB:OPTS_ISA_LSB],
      OPTS_STATUS[OPTS_MMU_MSB:OPTS_MMU_LSB], OPTS_STATUS[OPTS_ICACHE_BIT]})
  else $error("decoded options fields changed");

  chk_policy_write: assert property (
    @(posedge clk) disable iff (rst)
    wrOpts |=> cachedSegmentPolicy == $past(cpWrData[POLICY_W-1:0]))
  else $error("policy field write lost");

  chk_policy_decode: assert property (
    @(posedge clk) disable iff (rst)
    (cachedSegmentPolicy == POLICY_CACHEABLE) [*2] |-> segmentCacheable &&
      !segmentPolicyReserved)
  else $error("cacheable policy not decoded");

  chk_read_answer: assert property (
    @(posedge clk) disable iff (rst)
    cpRead |=> cpRdValid ##1 !cpRdValid || $past(cpRead))
  else $error("read answer timing wrong");

  cov_vbase_write_read: cover property (
    @(posedge clk) disable iff (rst)
    wrVbase ##[1:4] (cpRead && hitVbase));

  cov_policy_uncached: cover property (
    @(posedge clk) disable iff (rst)
    wrOpts && cpWrData[POLICY_W-1:0] == POLICY_UNCACHED);

  cov_unmapped_read: cover property (
    @(posedge clk) disable iff (rst)
    cpRead && !hitVbase && !hitOpts);

  cov_boot_vector_toggle: cover property (
    @(posedge clk) disable iff (rst)
    $fell(bootVectorSelect));

endmodule

// ==== core/cvbo_sync2.sv ====
// Two-stage synchroniser for a bus of pin levels.
// Assumes the levels change slowly compared with the clock.
`timescale 1ns/10ps
module cvbo_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    stage1 <= pinIn;
    syncOut <= stage1;
  end

endmodule

// ==== shared/cvbo_pkg.sv ====
// Constants for the vector base and core options register pair.
// Assumes a core that reaches these registers by register number and select.
package cvbo_pkg;

  // ************************************************************
  // Register addressing
  // ************************************************************
  localparam logic [4:0] VBASE_REG_NUM = 5'h0f;
  localparam logic [2:0] VBASE_REG_SEL = 3'h1;
  localparam logic [4:0] OPTS_REG_NUM = 5'h10;
  localparam logic [2:0] OPTS_REG_SEL = 3'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ************************************************************
  // Vector base register layout
  // ************************************************************
  localparam int VBASE_TOP_MSB = 31;
  localparam int VBASE_TOP_LSB = 30;
  localparam logic [1:0] VBASE_TOP_VALUE = 2'h2;
  localparam int VBASE_BASE_MSB = 29;
  localparam int VBASE_BASE_LSB = 12;
  localparam int VBASE_BASE_W = 18;
  localparam logic [VBASE_BASE_W-1:0] VBASE_BASE_RESET = 18'h00000;
  localparam int VBASE_RSV_MSB = 11;
  localparam int VBASE_RSV_LSB = 10;
  localparam logic [1:0] VBASE_RSV_VALUE = 2'h0;
  localparam int CORE_INDEX_W = 10;
  localparam logic [11:0] VBASE_ALIGN_ZERO = 12'h000;

  // ************************************************************
  // Core options register layout
  // ************************************************************
  localparam logic [31:0] OPTS_RESET = 32'h0003_0932;
  localparam int OPTS_STATUS_LSB = 3;
  localparam int OPTS_STATUS_W = 29;
  localparam int OPTS_NEXT_BIT = 31;
  localparam int OPTS_ENDIAN_BIT = 15;
  localparam int OPTS_ARCH_MSB = 14;
  localparam int OPTS_ARCH_LSB = 13;
  localparam int OPTS_ISA_MSB = 12;
  localparam int OPTS_ISA_LSB = 10;
  localparam int OPTS_MMU_MSB = 9;
  localparam int OPTS_MMU_LSB = 7;
  localparam int OPTS_ICACHE_BIT = 3;
  localparam int POLICY_W = 3;
  localparam logic [POLICY_W-1:0] POLICY_UNCACHED = 3'h2;
  localparam logic [POLICY_W-1:0] POLICY_CACHEABLE = 3'h3;
  localparam logic [POLICY_W-1:0] POLICY_RESET = 3'h2;

endpackage

// ==== tb/tb.sv ====
// Self-checking bench for the vector base and core options register pair.
// Assumes cvbo_pkg is compiled first and cvbo_regs with its helper modules.
`timescale 1ns/10ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("FAIL %0t %s", $time, m); end end

module tb;
  import cvbo_pkg::*;

  // ************************************************************
  // Signals and model state
  // ************************************************************
  localparam logic [31:0] OPTS = 32'h0003_0932;
  localparam logic [31:0] BOOT = 32'h8000_0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cpRead = 1'b0;
  logic cpWrite = 1'b0;
  logic [4:0] cpRegNum = 5'h00;
  logic [2:0] cpSel = 3'h0;
  logic [31:0] cpWrData = 32'h0000_0000;
  logic bootVectorSelect = 1'b0;
  logic [9:0] coreIndexPins = 10'h000;
  logic [31:0] cpRdData;
  logic cpRdValid;
  logic [31:0] vectorBase;
  logic [2:0] cachedSegmentPolicy;
  logic segmentCacheable;
  logic segmentPolicyReserved;
  logic nextRegPresent;
  logic endianFlag;
  logic [1:0] archType;
  logic [2:0] isaRevision;
  logic [2:0] mmuKind;
  logic icacheLogicalTagged;
  int err_count = 0;
  int cmp_count = 0;
  int mBase;
  int mPol;
  int mIdx;
  logic [31:0] w;
  logic [31:0] d;

  cvbo_regs #(.OPTS_STATUS(OPTS), .BOOT_VECTOR_BASE(BOOT)) cvbo_regs_inst (
    .clk(clk),
    .rst(rst),
    .cpRead(cpRead),
    .cpWrite(cpWrite),
    .cpRegNum(cpRegNum),
    .cpSel(cpSel),
    .cpWrData(cpWrData),
    .bootVectorSelect(bootVectorSelect),
    .coreIndexPins(coreIndexPins),
    .cpRdData(cpRdData),
    .cpRdValid(cpRdValid),
    .vectorBase(vectorBase),
    .cachedSegmentPolicy(cachedSegmentPolicy),
    .segmentCacheable(segmentCacheable),
    .segmentPolicyReserved(segmentPolicyReserved),
    .nextRegPresent(nextRegPresent),
    .endianFlag(endianFlag),
    .archType(archType),
    .isaRevision(isaRevision),
    .mmuKind(mmuKind),
    .icacheLogicalTagged(icacheLogicalTagged)
  );

  always #50 clk = ~clk;

  // ************************************************************
  // Tasks
  // ************************************************************
  function automatic logic [31:0] expVb();
    return {2'h2, mBase[17:0], 2'h0, mIdx[9:0]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rdReg(input logic [4:0] n, input logic [2:0] s, output logic [31:0] q);
    cpRead = 1'b1;
    cpRegNum = n;
    cpSel = s;
    @(negedge clk);
    cpRead = 1'b0;
    `CHK(cpRdValid, 1'b1, "no read answer")
    q = cpRdData;
  endtask

  task automatic wrReg(input logic [4:0] n, input logic [2:0] s, input logic [31:0] v);
    cpWrite = 1'b1;
    cpRegNum = n;
    cpSel = s;
    cpWrData = v;
    @(negedge clk);
    cpWrite = 1'b0;
  endtask

  task automatic checkAll();
    logic [31:0] q;
    step(2);
    `CHK(vectorBase, bootVectorSelect ? BOOT : {2'h2, mBase[17:0], 12'h000}, "vector base")
    `CHK(cachedSegmentPolicy, mPol[2:0], "policy field")
    `CHK(segmentCacheable, 1'(mPol == 3), "cacheable flag")
    `CHK(segmentPolicyReserved, 1'(mPol != 2 && mPol != 3), "reserved policy flag")
    rdReg(VBASE_REG_NUM, VBASE_REG_SEL, q);
    `CHK(q, expVb(), "vector base word")
    rdReg(OPTS_REG_NUM, OPTS_REG_SEL, q);
    `CHK(q, {OPTS[31:3], mPol[2:0]}, "options word")
  endtask

  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(78243));
    coreIndexPins = 10'($urandom);
    mIdx = coreIndexPins;
    mBase = 0;
    mPol = 2;
    step(20);
    rst = 1'b0;
    `CHK(nextRegPresent, OPTS[31], "next register flag")
    `CHK(endianFlag, OPTS[15], "byte order flag")
    `CHK(archType, OPTS[14:13], "arch type")
    `CHK({isaRevision, mmuKind}, OPTS[12:7], "revision and mapping")
    `CHK(icacheLogicalTagged, OPTS[3], "icache tag flag")
    checkAll();
    // Index pins move after reset; the reported index must not
    coreIndexPins = ~coreIndexPins;
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0000 : $urandom;
      w = w & 32'hbfff_f3ff;
      wrReg(VBASE_REG_NUM, VBASE_REG_SEL, w);
      mBase = int'(w[29:12]);
      rdReg(VBASE_REG_NUM, VBASE_REG_SEL, d);
      `CHK(d, expVb(), "vector base read after write")
      bootVectorSelect = i[0];
      checkAll();
    end
    bootVectorSelect = 1'b0;
    for (int p = 0; p < 8; p++) begin
      wrReg(OPTS_REG_NUM, OPTS_REG_SEL, {29'h0, 3'(p)});
      mPol = p;
      checkAll();
    end
    // Unmapped place: write ignored, read answers zero
    wrReg(5'h10, 3'h5, 32'hffff_f3ff);
    rdReg(5'h10, 3'h5, d);
    `CHK(d, 32'h0000_0000, "unmapped read")
    checkAll();
    // Read and write in one cycle return the old word
    w = $urandom & 32'hbfff_f3ff;
    cpRead = 1'b1;
    cpWrite = 1'b1;
    cpRegNum = VBASE_REG_NUM;
    cpSel = VBASE_REG_SEL;
    cpWrData = w;
    @(negedge clk);
    cpRead = 1'b0;
    cpWrite = 1'b0;
    `CHK(cpRdData, expVb(), "read beside write")
    mBase = int'(w[29:12]);
    checkAll();
    // Second reset takes the new index and reset values
    rst = 1'b1;
    step(4);
    rst = 1'b0;
    mIdx = coreIndexPins;
    mBase = 0;
    mPol = 2;
    checkAll();
    end_of_test();
  end

  initial begin
    #(100 * 5000);
    err_count++;
    $display("FAIL %0t run too long", $time);
    end_of_test();
  end
endmodule
